// File: design/ucm_modem_ctrl.sv
// Modem control, modem status, interrupt mask, cause and scratch registers.
// Assumes rd_strobe and wr_strobe are one-cycle pulses on mclk from the CPU
// port logic, and that the line-error, data-ready and holding-empty flags
// come from the rest of the controller on the same clock.
//
// How it works
// - Mask bit 0 lets received-data-available raise an interrupt.
// - Mask bit 1 lets transmit-holding-empty raise an interrupt.
// - Mask bit 2 lets receiver line errors raise an interrupt.
// - Mask bit 3 lets modem status changes raise an interrupt.
// - Mask bits 4 to 7 always read zero.
// - Masked sources never show in the cause register or interrupt output.
// - Status flags keep setting regardless of the mask.
// - Control bit 0 drives DTR pin inverted.
// - Control bits 1 to 3 drive RTS and auxiliary pins inverted.
// - Loopback holds serial output at mark and loops transmit into receive.
// - Loopback ignores modem inputs, loops outputs internally, forces pins high.
// - Loopback keeps all interrupts working; modem sources become control bits.
// - Control bits 5 to 7 always read zero.
// - Reading modem status clears the four change flags.
// - CTS, DSR and DCD level changes set status bits 0, 1, 3.
// - Status bit 2 sets only when the ring level falls: ring input rising at the pin, AUX1 clearing in loopback, or a loopback switch.
// - Any change flag raises the modem interrupt condition, masked.
// - Status bits 4 to 7 show inverted CTS, DSR, RI, DCD pins.
// - In loopback status bits 4 to 7 show RTS, DTR, AUX1, AUX2.
// - Scratch byte stores and returns the last write, nothing else.
// - Priority: line errors, received data, holding empty, modem status.
// - Overrun, parity, framing and break flags form the line error source.
`timescale 1ns/10ps
module ucm_modem_ctrl (
  // Clock and reset.
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  // CPU register port.
  input  wire logic [2:0]              reg_addr,
  input  wire logic                    rd_strobe,
  input  wire logic                    wr_strobe,
  input  wire logic [7:0]              wr_data,
  output logic      [7:0]              rd_data,
  // Interrupt sources from the rest of the controller.
  input  wire logic [3:0]              line_err_flags,
  input  wire logic                    rx_data_avail,
  input  wire logic                    tx_holding_empty,
  // Interrupt outputs.
  output logic                         interrupt_output,
  output logic                         tx_empty_cause_read,
  // Serial path.
  input  wire logic                    tx_shift_out,
  output logic                         rx_shift_in,
  output logic                         serial_tx_pin,
  input  wire logic                    serial_rx_pin,
  // Modem pins, active low.
  input  wire logic                    cts_n_pin,
  input  wire logic                    dsr_n_pin,
  input  wire logic                    ri_n_pin,
  input  wire logic                    dcd_n_pin,
  output ucm_pkg::ucm_modem_out_t      modem_out_pins
);

  logic [7:0]          interrupt_mask_reg;
  logic [7:0]          modem_line_control_reg;
  logic [7:0]          scratch_byte_reg;
  logic [3:0]          change_flags_reg;
  logic [3:0]          change_flags_next;
  ucm_pkg::ucm_modem_t line_level_reg;
  ucm_pkg::ucm_modem_t line_level_next;
  ucm_pkg::ucm_modem_t pin_level;
  logic                rx_pin_level;
  logic [3:0]          pin_level_n;
  logic                loop_mode;
  logic                src_line_err;
  logic                src_rx_data;
  logic                src_tx_empty;
  logic                src_modem;
  logic [2:0]          cause_code;
  logic                modem_state_read;
  logic                cause_read;
  logic [7:0]          rd_data_next;
  logic                line_level_valid_reg;

  assign loop_mode = modem_line_control_reg[ucm_pkg::MC_LOOP];

  // Conditioners for the four modem inputs, in status bit order.
  assign pin_level_n = {dcd_n_pin, ri_n_pin, dsr_n_pin, cts_n_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_modem_filter
      logic filt_level;
      ucm_pin_filter #(
        .RESET_LEVEL (ucm_pkg::PIN_IDLE_LEVEL)
      ) u_filter (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .pin_in    (pin_level_n[gi]),
        .level_out (filt_level)
      );
      // The pins are active low, so the line level is the complement.
      assign pin_level[gi] = ~filt_level;
    end
  endgenerate

  // Conditioner for the serial receive pin.
  ucm_pin_filter #(
    .RESET_LEVEL (ucm_pkg::PIN_IDLE_LEVEL)
  ) u_rx_filter (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .pin_in    (serial_rx_pin),
    .level_out (rx_pin_level)
  );

  assign modem_state_read = rd_strobe && (reg_addr == ucm_pkg::ADDR_MODEM_STATE);
  assign cause_read       = rd_strobe && (reg_addr == ucm_pkg::ADDR_INTERRUPT_CAUSE);

  // Interrupt mask; only the low four bits hold state.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      interrupt_mask_reg <= ucm_pkg::RST_INTERRUPT_MASK;
    else if (wr_strobe && reg_addr == ucm_pkg::ADDR_INTERRUPT_MASK)
      interrupt_mask_reg <= wr_data & ucm_pkg::IM_WRITABLE;
  end

  // Modem control; loopback and the four output controls.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      modem_line_control_reg <= ucm_pkg::RST_MODEM_CONTROL;
    else if (wr_strobe && reg_addr == ucm_pkg::ADDR_MODEM_CONTROL)
      modem_line_control_reg <= wr_data & ucm_pkg::MC_WRITABLE;
  end

  // Scratch byte; read back only, steers nothing.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      scratch_byte_reg <= ucm_pkg::RST_SCRATCH;
    else if (wr_strobe && reg_addr == ucm_pkg::ADDR_SCRATCH)
      scratch_byte_reg <= wr_data;
  end

  // Current line levels: pins in normal mode, control bits in loopback.
  always_comb
  begin
    if (loop_mode)
    begin
      line_level_next.cts = modem_line_control_reg[ucm_pkg::MC_RTS];
      line_level_next.dsr = modem_line_control_reg[ucm_pkg::MC_DTR];
      line_level_next.ri  = modem_line_control_reg[ucm_pkg::MC_AUX1];
      line_level_next.dcd = modem_line_control_reg[ucm_pkg::MC_AUX2];
    end
    else
    begin
      line_level_next = pin_level;
    end
  end

  // Level history for change detection. The first cycle after reset only
  // loads the history, so reset itself never reports a spurious change.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      line_level_reg       <= '0;
      line_level_valid_reg <= 1'b0;
    end
    else
    begin
      line_level_reg       <= line_level_next;
      line_level_valid_reg <= 1'b1;
    end
  end

  // Change flags: a new change in the same cycle as a status read wins.
  always_comb
  begin
    change_flags_next = change_flags_reg;
    if (modem_state_read)
      change_flags_next = 4'h0;
    if (line_level_valid_reg)
    begin
      if (line_level_next.cts != line_level_reg.cts)
        change_flags_next[0] = 1'b1;
      if (line_level_next.dsr != line_level_reg.dsr)
        change_flags_next[1] = 1'b1;
      if (line_level_next.dcd != line_level_reg.dcd)
        change_flags_next[3] = 1'b1;
      if (line_level_reg.ri && !line_level_next.ri)
        change_flags_next[2] = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      change_flags_reg <= 4'h0;
    else
      change_flags_reg <= change_flags_next;
  end

  // Masked interrupt sources.
  // line errors masked
  assign src_line_err = interrupt_mask_reg[ucm_pkg::IM_LINE_ERR] && (|line_err_flags);
  assign src_rx_data  = interrupt_mask_reg[ucm_pkg::IM_RX_DATA] && rx_data_avail;
  assign src_tx_empty = interrupt_mask_reg[ucm_pkg::IM_TX_EMPTY] && tx_holding_empty;
  assign src_modem    = interrupt_mask_reg[ucm_pkg::IM_MODEM] && (|change_flags_reg);

  // Priority encoder for the cause code.
  always_comb
  begin
    if (src_line_err)
      cause_code = ucm_pkg::CAUSE_LINE_ERR;
    else if (src_rx_data)
      cause_code = ucm_pkg::CAUSE_RX_DATA;
    else if (src_tx_empty)
      cause_code = ucm_pkg::CAUSE_TX_EMPTY;
    else if (src_modem)
      cause_code = ucm_pkg::CAUSE_MODEM;
    else
      cause_code = ucm_pkg::CAUSE_NONE;
  end

  // Interrupt line; registered so it never glitches on the pin.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      interrupt_output <= 1'b0;
    else
      interrupt_output <= src_line_err || src_rx_data || src_tx_empty || src_modem;
  end

  // Tells the transmitter that software has seen the holding-empty cause,
  // which is what clears that source when it is the one indicated.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      tx_empty_cause_read <= 1'b0;
    else
      tx_empty_cause_read <= cause_read && (cause_code == ucm_pkg::CAUSE_TX_EMPTY);
  end

  // Read multiplexer. Data are captured on the strobe and held, which also
  // freezes the cause code seen by software for the rest of the access.
  always_comb
  begin
    case (reg_addr)
      ucm_pkg::ADDR_INTERRUPT_MASK:  rd_data_next = interrupt_mask_reg;
      ucm_pkg::ADDR_INTERRUPT_CAUSE: rd_data_next = {5'h00, cause_code};
      ucm_pkg::ADDR_MODEM_CONTROL:   rd_data_next = modem_line_control_reg;
      ucm_pkg::ADDR_MODEM_STATE:     rd_data_next = {line_level_reg, change_flags_reg};
      ucm_pkg::ADDR_SCRATCH:         rd_data_next = scratch_byte_reg;
      default:                       rd_data_next = ucm_pkg::READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      rd_data <= ucm_pkg::READ_UNMAPPED;
    else if (rd_strobe)
      rd_data <= rd_data_next;
  end

  // Modem output pins: inverted control bits, idle high in loopback.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      modem_out_pins <= {4{ucm_pkg::PIN_IDLE_LEVEL}};
    else if (loop_mode)
      modem_out_pins <= {4{ucm_pkg::PIN_IDLE_LEVEL}};
    else
    begin
      modem_out_pins.dtr_n  <= ~modem_line_control_reg[ucm_pkg::MC_DTR];
      modem_out_pins.rts_n  <= ~modem_line_control_reg[ucm_pkg::MC_RTS];
      modem_out_pins.aux1_n <= ~modem_line_control_reg[ucm_pkg::MC_AUX1];
      modem_out_pins.aux2_n <= ~modem_line_control_reg[ucm_pkg::MC_AUX2];
    end
  end

  // Serial path. The receive side sees the conditioned pin, or the
  // transmitter directly in loopback; both paths add one register.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      serial_tx_pin <= ucm_pkg::PIN_IDLE_LEVEL;
      rx_shift_in   <= ucm_pkg::PIN_IDLE_LEVEL;
    end
    else if (loop_mode)
    begin
      serial_tx_pin <= ucm_pkg::PIN_IDLE_LEVEL;
      rx_shift_in   <= tx_shift_out;
    end
    else
    begin
      serial_tx_pin <= tx_shift_out;
      rx_shift_in   <= rx_pin_level;
    end
  end

endmodule : ucm_modem_ctrl

// File: design/ucm_pin_filter.sv
// Three-stage input conditioner for one asynchronous pin.
// Assumes the pin is unrelated to mclk; the output moves only once stages two
// and three agree, so a single-cycle glitch after the first stage is rejected.
`timescale 1ns/10ps
module ucm_pin_filter #(
  parameter logic RESET_LEVEL = 1'h1
) (
  // Clock and reset.
  input  wire logic mclk,
  input  wire logic rst_n,
  // Raw pin and conditioned level.
  input  wire logic pin_in,
  output logic      level_out
);

  logic stage1_reg;
  logic stage2_reg;
  logic stage3_reg;

  // Synchroniser chain; stage one feeds stage two only.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      stage1_reg <= RESET_LEVEL;
      stage2_reg <= RESET_LEVEL;
      stage3_reg <= RESET_LEVEL;
    end
    else
    begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // Accept a new level only when the two settled stages agree.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      level_out <= RESET_LEVEL;
    else if (stage2_reg == stage3_reg)
      level_out <= stage3_reg;
  end

endmodule : ucm_pin_filter

// File: design/ucm_pkg.sv
// Shared constants and carriers for the modem-control and interrupt-enable block.
// Assumes one 25 MHz clock and a byte-wide register port with a 3-bit address.
package ucm_pkg;

  // Register addresses on the 3-bit CPU register port.
  localparam logic [2:0] ADDR_INTERRUPT_MASK  = 3'h1;
  localparam logic [2:0] ADDR_INTERRUPT_CAUSE = 3'h2;
  localparam logic [2:0] ADDR_MODEM_CONTROL   = 3'h4;
  localparam logic [2:0] ADDR_MODEM_STATE     = 3'h6;
  localparam logic [2:0] ADDR_SCRATCH         = 3'h7;

  // Reset values.
  localparam logic [7:0] RST_INTERRUPT_MASK = 8'h00;
  localparam logic [7:0] RST_MODEM_CONTROL  = 8'h00;
  localparam logic [7:0] RST_SCRATCH        = 8'h00;
  localparam logic [7:0] READ_UNMAPPED      = 8'h00;
  localparam logic       PIN_IDLE_LEVEL     = 1'h1;

  // Interrupt mask field positions.
  localparam int IM_RX_DATA   = 0;
  localparam int IM_TX_EMPTY  = 1;
  localparam int IM_LINE_ERR  = 2;
  localparam int IM_MODEM     = 3;
  localparam logic [7:0] IM_WRITABLE = 8'h0f;

  // Modem control field positions.
  localparam int MC_DTR  = 0;
  localparam int MC_RTS  = 1;
  localparam int MC_AUX1 = 2;
  localparam int MC_AUX2 = 3;
  localparam int MC_LOOP = 4;
  localparam logic [7:0] MC_WRITABLE = 8'h1f;

  // Interrupt cause codes in bits 2..0; bit 0 low means pending.
  localparam logic [2:0] CAUSE_NONE      = 3'h1;
  localparam logic [2:0] CAUSE_LINE_ERR  = 3'h6;
  localparam logic [2:0] CAUSE_RX_DATA   = 3'h4;
  localparam logic [2:0] CAUSE_TX_EMPTY  = 3'h2;
  localparam logic [2:0] CAUSE_MODEM     = 3'h0;

  // Modem line levels, active high, in modem status bit order.
  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } ucm_modem_t;

  // Modem output pin levels as driven, active low.
  typedef struct packed {
    logic aux2_n;
    logic aux1_n;
    logic rts_n;
    logic dtr_n;
  } ucm_modem_out_t;

endpackage : ucm_pkg

// File: verif/ucm_modem_ctrl_chk.sv
// Checker for the modem control block, seeing only the top module ports.
// Assumes a free running mclk and a synchronous active-low rst_n.
`timescale 1ns/10ps
module ucm_modem_ctrl_chk (
  // Clock and reset.
  input wire logic                    mclk,
  input wire logic                    rst_n,
  // Register port.
  input wire logic [2:0]              reg_addr,
  input wire logic                    rd_strobe,
  input wire logic                    wr_strobe,
  input wire logic [7:0]              wr_data,
  input wire logic [7:0]              rd_data,
  // Sources and outputs.
  input wire logic [3:0]              line_err_flags,
  input wire logic                    rx_data_avail,
  input wire logic                    tx_holding_empty,
  input wire logic                    interrupt_output,
  input wire logic                    tx_empty_cause_read,
  input wire logic                    tx_shift_out,
  input wire logic                    rx_shift_in,
  input wire logic                    serial_tx_pin,
  input wire ucm_pkg::ucm_modem_out_t modem_out_pins
);
  logic [7:0] mask_q;
  logic [7:0] ctl_q;
  logic [7:0] scr_q;
  logic [7:0] exp_rd;
  logic [2:0] exp_cause;
  logic       exp_irq;
  logic       run_q;

  // Mirror of the writable registers, so reads are predicted from writes alone.
  always_ff @(posedge mclk)
  begin
    run_q <= rst_n;
    if (!rst_n)
    begin
      mask_q <= 8'h00;
      ctl_q  <= 8'h00;
      scr_q  <= 8'h00;
    end
    else if (wr_strobe)
    begin
      if (reg_addr == 3'h1) mask_q <= wr_data & 8'h0f;
      if (reg_addr == 3'h4) ctl_q <= wr_data & 8'h1f;
      if (reg_addr == 3'h7) scr_q <= wr_data;
    end
  end

  // Expected read data, cause code and interrupt level; modem flags are not visible here.
  always_comb
  begin
    exp_rd = 8'h00;
    if (reg_addr == 3'h1) exp_rd = mask_q;
    if (reg_addr == 3'h4) exp_rd = ctl_q;
    if (reg_addr == 3'h7) exp_rd = scr_q;
    exp_irq = (mask_q[0] & rx_data_avail) | (mask_q[1] & tx_holding_empty)
            | (mask_q[2] & (|line_err_flags));
    if (mask_q[2] && (|line_err_flags)) exp_cause = 3'h6;
    else if (mask_q[0] && rx_data_avail) exp_cause = 3'h4;
    else if (mask_q[1] && tx_holding_empty) exp_cause = 3'h2;
    else exp_cause = 3'h1;
  end

  // The first cycle after reset still shows reset values, so it is skipped.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n || !run_q);

  sequence s_rd_plain;
    rd_strobe && !(reg_addr inside {3'h2, 3'h6});
  endsequence
  sequence s_rd_cause;
    rd_strobe && reg_addr == 3'h2 && !mask_q[3];
  endsequence

  property p_reg_read;
    s_rd_plain |=> rd_data == $past(exp_rd);
  endproperty
  a_reg_read: assert property (p_reg_read) else $error("register read data wrong");
  property p_cause;
    s_rd_cause |=> rd_data == {5'h00, $past(exp_cause)};
  endproperty
  a_cause: assert property (p_cause) else $error("cause code wrong");
  property p_tx_holding_empty;
    s_rd_cause |=> tx_empty_cause_read == ($past(exp_cause) == 3'h2);
  endproperty
  a_tx_holding_empty: assert property (p_tx_holding_empty) else $error("holding empty read pulse wrong");
  property p_irq;
    !mask_q[3] |=> interrupt_output == $past(exp_irq);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");
  property p_pins;
    modem_out_pins == ($past(ctl_q[4]) ? 4'hf : ~$past(ctl_q[3:0]));
  endproperty
  a_pins: assert property (p_pins) else $error("modem output pins wrong");
  property p_tx;
    serial_tx_pin == ($past(ctl_q[4]) | $past(tx_shift_out));
  endproperty
  a_tx: assert property (p_tx) else $error("serial output wrong");
  property p_rx_loop;
    $past(ctl_q[4]) |-> rx_shift_in == $past(tx_shift_out);
  endproperty
  a_rx_loop: assert property (p_rx_loop) else $error("loopback receive wrong");
  property p_hold;
    !rd_strobe |=> $stable(rd_data);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
endmodule : ucm_modem_ctrl_chk

bind ucm_modem_ctrl ucm_modem_ctrl_chk u_chk (.mclk, .rst_n, .reg_addr, .rd_strobe,
  .wr_strobe, .wr_data, .rd_data, .line_err_flags, .rx_data_avail, .tx_holding_empty,
  .interrupt_output, .tx_empty_cause_read, .tx_shift_out, .rx_shift_in, .serial_tx_pin,
  .modem_out_pins);

// File: verif/ucm_modem_ctrl_tb_top.sv
// Self-checking bench for the modem control block with a modem model.
// Assumes inputs change at the falling edge of a 25 MHz mclk.
`timescale 1ns/10ps
module ucm_modem_ctrl_tb_top;
  logic                    mclk = 1'b0;
  logic                    rst_n;
  logic [2:0]              reg_addr;
  logic                    rd_strobe;
  logic                    wr_strobe;
  logic [7:0]              wr_data;
  logic [7:0]              rd_data;
  logic [3:0]              line_err_flags;
  logic                    rx_data_avail;
  logic                    tx_holding_empty;
  logic                    interrupt_output;
  logic                    tx_empty_cause_read;
  logic                    tx_shift_out;
  logic                    rx_shift_in;
  logic                    serial_tx_pin;
  logic                    serial_rx_pin;
  logic                    cts_n_pin;
  logic                    dsr_n_pin;
  logic                    ri_n_pin;
  logic                    dcd_n_pin;
  ucm_pkg::ucm_modem_out_t modem_out_pins;
  ucm_pkg::ucm_modem_t     line_on;
  int                      bad_count = 0;
  int                      tests_run = 0;

  ucm_modem_ctrl u_dut (.mclk, .rst_n, .reg_addr, .rd_strobe, .wr_strobe, .wr_data,
    .rd_data, .line_err_flags, .rx_data_avail, .tx_holding_empty, .interrupt_output,
    .tx_empty_cause_read, .tx_shift_out, .rx_shift_in, .serial_tx_pin, .serial_rx_pin,
    .cts_n_pin, .dsr_n_pin, .ri_n_pin, .dcd_n_pin, .modem_out_pins);
  ucm_modem_partner u_partner (.line_on, .cts_n_pin, .dsr_n_pin, .ri_n_pin, .dcd_n_pin);

  // Free running clock of 40 ns period.
  always #20 mclk = ~mclk;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  // Strobes are dropped a full cycle later, so back-to-back calls never clash.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge mclk);
    wr_strobe = 1'b1;
    reg_addr  = a;
    wr_data   = d;
    @(negedge mclk);
    wr_strobe = 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(negedge mclk);
    rd_strobe = 1'b1;
    reg_addr  = a;
    @(negedge mclk);
    rd_strobe = 1'b0;
    chk(rd_data, exp);
  endtask : rd

  task automatic t_regs;
    chk(modem_out_pins, 8'h0f);
    rd(3'h7, 8'h00);
    wr(3'h1, 8'hff);
    rd(3'h1, 8'h0f);
    wr(3'h4, 8'he0);
    rd(3'h4, 8'h00);
    wr(3'h7, 8'ha5);
    wr(3'h3, 8'h5a);
    wr(3'h6, 8'hff);
    rd(3'h3, 8'h00);
    rd(3'h7, 8'ha5);
    chk(modem_out_pins, 8'h0f);
    wr(3'h1, 8'h00);
  endtask : t_regs

  task automatic t_pins;
    for (int i = 0; i < 4; i++)
    begin
      wr(3'h4, 8'h01 << i);
      cyc(2);
      chk(modem_out_pins, ~(8'h01 << i) & 8'h0f);
    end
    wr(3'h4, 8'h00);
  endtask : t_pins

  task automatic t_irq;
    logic [7:0] mk[6] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h03, 8'h06};
    logic [7:0] ex[6] = '{8'h01, 8'h04, 8'h02, 8'h06, 8'h04, 8'h06};
    rx_data_avail    = 1'b1;
    tx_holding_empty = 1'b1;
    line_err_flags   = 4'h2;
    for (int i = 0; i < 6; i++)
    begin
      wr(3'h1, mk[i]);
      cyc(1);
      chk(interrupt_output, ex[i] != 8'h01);
      rd(3'h2, ex[i]);
      chk(tx_empty_cause_read, ex[i] == 8'h02);
    end
    rx_data_avail    = 1'b0;
    tx_holding_empty = 1'b0;
    wr(3'h1, 8'h04);
    for (int b = 0; b < 5; b++)
    begin
      line_err_flags = 4'h1 << b;
      cyc(2);
      rd(3'h2, (b < 4) ? 8'h06 : 8'h01);
    end
    wr(3'h1, 8'h00);
  endtask : t_irq

  task automatic t_modem;
    logic [3:0] nib;
    for (int i = 0; i < 4; i++)
    begin
      nib     = 4'h1 << i;
      line_on = nib;
      cyc(10);
      rd(3'h6, {nib, (i == 2) ? 4'h0 : nib});
      chk(interrupt_output, 1'b0);
      line_on = 4'h0;
      cyc(10);
      rd(3'h6, {4'h0, nib});
      rd(3'h6, 8'h00);
    end
    wr(3'h1, 8'h08);
    line_on = 4'h1;
    cyc(10);
    chk(interrupt_output, 1'b1);
    rd(3'h2, 8'h00);
    rd(3'h6, 8'h11);
    cyc(2);
    chk(interrupt_output, 1'b0);
    line_on = 4'h0;
    cyc(10);
    rd(3'h6, 8'h01);
  endtask : t_modem

  task automatic t_loop;
    serial_rx_pin = 1'b0;
    cyc(8);
    chk(rx_shift_in, 1'b0);
    serial_rx_pin = 1'b1;
    line_on       = 4'hf;
    wr(3'h4, 8'h13);
    cyc(3);
    chk(modem_out_pins, 8'h0f);
    chk(interrupt_output, 1'b1);
    rd(3'h6, 8'h33);
    rd(3'h6, 8'h30);
    for (int k = 0; k < 4; k++)
    begin
      tx_shift_out = k[0];
      cyc(1);
      chk(rx_shift_in, k[0]);
      chk(serial_tx_pin, 1'b1);
    end
    wr(3'h4, 8'h1c);
    cyc(3);
    rd(3'h6, 8'hcb);
    wr(3'h4, 8'h10);
    cyc(3);
    rd(3'h6, 8'h0c);
    line_on = 4'h0;
    cyc(10);
    wr(3'h4, 8'h00);
    cyc(10);
    rd(3'h6, 8'h00);
    wr(3'h1, 8'h00);
  endtask : t_loop

  // A level change landing on the very edge of a status read must survive it.
  task automatic t_race;
    wr(3'h4, 8'h10);
    cyc(2);
    rd(3'h6, 8'h00);
    @(negedge mclk);
    wr_strobe = 1'b1;
    reg_addr  = 3'h4;
    wr_data   = 8'h11;
    @(negedge mclk);
    wr_strobe = 1'b0;
    rd_strobe = 1'b1;
    reg_addr  = 3'h6;
    @(negedge mclk);
    rd_strobe = 1'b0;
    chk(rd_data, 8'h00);
    rd(3'h6, 8'h22);
    wr(3'h4, 8'h00);
    cyc(8);
    rd(3'h6, 8'h02);
  endtask : t_race

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  // Main sequence: reset for ten cycles, then each scenario in turn.
  initial
  begin
    rst_n            = 1'b0;
    reg_addr         = 3'h0;
    rd_strobe        = 1'b0;
    wr_strobe        = 1'b0;
    wr_data          = 8'h00;
    line_err_flags   = 4'h0;
    rx_data_avail    = 1'b0;
    tx_holding_empty = 1'b0;
    tx_shift_out     = 1'b1;
    serial_rx_pin    = 1'b1;
    line_on          = 4'h0;
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    cyc(8);
    t_regs();
    t_pins();
    t_irq();
    t_modem();
    t_loop();
    t_race();
    test_done();
  end

  // Watchdog well beyond the roughly 330 cycles the scenarios take.
  initial
  begin
    #800000;
    bad_count++;
    test_done();
  end
endmodule : ucm_modem_ctrl_tb_top

// File: verif/ucm_modem_partner.sv
// Behavioural modem driving the four handshake inputs of the device.
// Assumes the bench commands each line's asserted state; pins are active low.
`timescale 1ns/10ps
module ucm_modem_partner #(
  parameter int LAG_NS = 7
) (
  // Commanded line states, active high.
  input  wire ucm_pkg::ucm_modem_t line_on,
  // Pins towards the device, active low.
  output logic                     cts_n_pin,
  output logic                     dsr_n_pin,
  output logic                     ri_n_pin,
  output logic                     dcd_n_pin
);
  // The lag keeps pin moves away from mclk edges, since a modem is unrelated in phase.
  assign #(LAG_NS) cts_n_pin = ~line_on.cts;
  assign #(LAG_NS) dsr_n_pin = ~line_on.dsr;
  assign #(LAG_NS) ri_n_pin  = ~line_on.ri;
  assign #(LAG_NS) dcd_n_pin = ~line_on.dcd;
endmodule : ucm_modem_partner
